// >>> mbh_handler.sv
// Purpose: slave command handler for functions 03/04/05/06
// Assumes: byte stream from a framer that checks CRC; tx framer adds CRC
// Notes:   one request at a time; bytes arriving while busy are dropped
// Notes on behaviour
// - read request: address 1..247, function 03, start word, count 1..32
// - read reply: address, function, byte count twice words, then words
// - function 04 reads the same registers as 03
// - 0x01E2 two words return module name, low word first
// - 0x01E4 returns own slave address as one word
// - 0x01E7 holds reply delay, 0..30 ms, applied before replying
// - 0x01E8 holds watchdog timeout, 0..255 tenths of a second
// - 0x01EB reads timeout count; writing zero clears it
// - access to 0x3038 at broadcast address means host alive, never answered
// - coil write is function 05; FF00 on, 0000 off
// - coil write reply echoes address and value unchanged
// - coil 0x0000 drives output 0; coil 0x0080 its power-on value
// - coil 0x0103 picks watchdog mode 1 on, mode 0 off
// - coil 0x0104 enables watchdog; coil 0x010D on clears timeout status
// - coils 0x0100/0x0101 form protocol code; 01 this protocol, 00 ascii
// - register write is function 06, echoed on success
// - failure reply: address, function plus 0x80, exception code
// - unsupported function answers exception 01; addresses are zero-based
// - requests failing CRC are dropped without reply
`default_nettype none
module mbh_handler #(
	parameter int          CYC_MS  = mbh_pkg::CYC_PER_MS,
	parameter int          CYC_WD  = mbh_pkg::CYC_PER_WD,
	parameter logic [31:0] NAME_ID = 32'h00A5_5A00  // arbitrary identifier
) (
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic [7:0] own_addr,
	input  wire logic [7:0] rx_data,
	input  wire logic       rx_valid,
	input  wire logic       rx_end,
	input  wire logic       rx_crc_ok,
	output logic      [7:0] tx_data,
	output logic            tx_valid,
	output logic            tx_last,
	input  wire logic       tx_ready,
	output logic            dout,
	output logic            dout_poweron,
	output logic            wd_mode,
	output logic            wd_enable,
	output logic            wd_status,
	output logic      [1:0] protocol_sel,
	output logic            host_alive,
	output logic     [15:0] reply_delay_ms,
	output logic     [15:0] host_alive_timeout,
	output logic     [15:0] host_alive_counter
);
	// ==========================================================
	// state
	typedef struct packed {
		mbh_pkg::mbh_state_t st;
		logic [5:0][7:0]     rq;
		logic [2:0]          nb;
		logic [7:0]          exc;
		logic [6:0]          idx;
		logic [6:0]          len;
		logic [15:0]         dly;
		logic [15:0]         wto;
		logic [15:0]         wcnt;
		logic [7:0]          elap;
		logic                dout;
		logic                dpor;
		logic                wmode;
		logic                wen;
		logic                wstat;
		logic [1:0]          proto;
		logic                hok;
		logic [7:0]          txd;
		logic [mbh_pkg::DIV_W-1:0] msdiv;
		logic [15:0]         msleft;
		logic [mbh_pkg::DIV_W-1:0] tdiv;
	} mbh_regs_t;
	mbh_regs_t q;
	mbh_regs_t next_q;

	// ==========================================================
	// decoding helpers
	function automatic logic read_ok(input logic [15:0] a, input logic [15:0] n);
		logic [15:0] e;
		e = 16'(a + n - 16'h0001);
		read_ok = ((a >= mbh_pkg::REG_NAME_LO) && (e <= mbh_pkg::REG_SLAVE)) ||
			((a >= mbh_pkg::REG_DELAY) && (e <= mbh_pkg::REG_WTO)) ||
			((a == mbh_pkg::REG_WCNT) && (n == 16'h0001));
	endfunction

	function automatic logic [15:0] rd_word(input mbh_regs_t s, input logic [15:0] a,
			input logic [7:0] me);
		case (a)
			mbh_pkg::REG_NAME_LO: rd_word = NAME_ID[15:0];
			mbh_pkg::REG_NAME_HI: rd_word = NAME_ID[31:16];
			mbh_pkg::REG_SLAVE:   rd_word = {8'h00, me};
			mbh_pkg::REG_DELAY:   rd_word = s.dly;
			mbh_pkg::REG_WTO:     rd_word = s.wto;
			mbh_pkg::REG_WCNT:    rd_word = s.wcnt;
			default:              rd_word = 16'h0000;
		endcase
	endfunction

	function automatic logic [7:0] tx_byte(input mbh_regs_t s, input logic [6:0] i,
			input logic [7:0] me);
		logic [15:0] w;
		logic        rd;
		w = rd_word(s, 16'({s.rq[2], s.rq[3]} + 16'(7'(i - 7'h03) >> 1)), me);
		rd = (s.rq[1] == mbh_pkg::FN_RD_HOLD) || (s.rq[1] == mbh_pkg::FN_RD_INPUT);
		if (i == 7'h00) begin
			tx_byte = s.rq[0];
		end else if (i == 7'h01) begin
			tx_byte = (s.exc != 8'h00) ? (s.rq[1] | mbh_pkg::EXC_FLAG) : s.rq[1];
		end else if (s.exc != 8'h00) begin
			tx_byte = s.exc;
		end else if (rd && i == 7'h02) begin
			tx_byte = 8'({s.rq[5], 1'b0});
		end else if (rd) begin
			tx_byte = i[0] ? w[15:8] : w[7:0];  // big-endian within word
		end else begin
			tx_byte = s.rq[3'(i)];
		end
	endfunction

	// ==========================================================
	// next state
	always_comb begin
		logic [7:0]  fn;
		logic [15:0] ra;
		logic [15:0] rv;
		logic        bc;
		logic        tick;
		fn = q.rq[1];
		ra = {q.rq[2], q.rq[3]};
		rv = {q.rq[4], q.rq[5]};
		bc = (q.rq[0] == mbh_pkg::BCAST_ADDR);
		tick = (q.tdiv == mbh_pkg::DIV_W'(CYC_WD - 1));
		next_q = q;
		next_q.hok = 1'b0;
		next_q.tdiv = tick ? '0 : mbh_pkg::DIV_W'(q.tdiv + 1'b1);
		case (q.st)
			mbh_pkg::ST_IDLE: begin
				if (rx_end) begin
					next_q.nb = 3'h0;
					// frames under two bytes, bad crc and other slaves are dropped silently
					if (rx_crc_ok && q.nb >= 3'h2 &&
							(q.rq[0] == own_addr || q.rq[0] == mbh_pkg::BCAST_ADDR)) begin
						next_q.nb = q.nb;
						next_q.st = mbh_pkg::ST_EXEC;
					end
				end else if (rx_valid && q.nb < mbh_pkg::REQ_BYTES) begin
					next_q.rq[q.nb] = rx_data;
					next_q.nb = 3'(q.nb + 3'h1);
				end
			end
			mbh_pkg::ST_EXEC: begin
				next_q.exc = 8'h00;
				next_q.len = mbh_pkg::ECHO_LEN;
				if (ra == mbh_pkg::REG_HOST_OK && fn >= mbh_pkg::FN_RD_HOLD &&
						fn <= mbh_pkg::FN_WR_REG && fn != mbh_pkg::FN_WR_COIL)
					next_q.hok = 1'b1;
				case (fn)
					mbh_pkg::FN_RD_HOLD, mbh_pkg::FN_RD_INPUT: begin
						if (q.nb < mbh_pkg::REQ_BYTES || rv == 16'h0000 ||
								rv > mbh_pkg::MAX_WORDS)
							next_q.exc = mbh_pkg::EXC_VALUE;
						else if (!read_ok(ra, rv))
							next_q.exc = mbh_pkg::EXC_ADDR;
						else
							next_q.len = 7'(mbh_pkg::RD_HDR_LEN + 7'({rv[5:0], 1'b0}));
					end
					mbh_pkg::FN_WR_COIL: begin
						if (q.nb < mbh_pkg::REQ_BYTES ||
								(rv != mbh_pkg::COIL_ON && rv != mbh_pkg::COIL_OFF)) begin
							next_q.exc = mbh_pkg::EXC_VALUE;
						end else begin
							case (ra)
								mbh_pkg::COIL_DOUT:   next_q.dout = rv[15];
								mbh_pkg::COIL_DPOR:   next_q.dpor = rv[15];
								mbh_pkg::COIL_PROTO0: next_q.proto[0] = rv[15];
								mbh_pkg::COIL_PROTO1: next_q.proto[1] = rv[15];
								mbh_pkg::COIL_WMODE:  next_q.wmode = rv[15];
								mbh_pkg::COIL_WEN:    next_q.wen = rv[15];
								mbh_pkg::COIL_WCLR: begin
									if (rv[15])
										next_q.wstat = 1'b0;
								end
								default: next_q.exc = mbh_pkg::EXC_ADDR;
							endcase
						end
					end
					mbh_pkg::FN_WR_REG: begin
						if (q.nb < mbh_pkg::REQ_BYTES) begin
							next_q.exc = mbh_pkg::EXC_VALUE;
						end else begin
							case (ra)
								mbh_pkg::REG_DELAY: begin
									if (rv <= mbh_pkg::DELAY_MAX) next_q.dly = rv;
									else next_q.exc = mbh_pkg::EXC_VALUE;
								end
								mbh_pkg::REG_WTO: begin
									if (rv <= mbh_pkg::WTO_MAX) next_q.wto = rv;
									else next_q.exc = mbh_pkg::EXC_VALUE;
								end
								mbh_pkg::REG_WCNT: begin
									if (rv == 16'h0000) next_q.wcnt = 16'h0000;
									else next_q.exc = mbh_pkg::EXC_VALUE;
								end
								mbh_pkg::REG_HOST_OK: next_q.elap = 8'h00;
								default: next_q.exc = mbh_pkg::EXC_ADDR;
							endcase
						end
					end
					default: next_q.exc = mbh_pkg::EXC_FUNC;
				endcase
				if (next_q.exc != 8'h00)
					next_q.len = mbh_pkg::EXC_LEN;
				// broadcast only carries the host-alive note; settings stay put
				if (bc) begin
					next_q.dout = q.dout;
					next_q.dpor = q.dpor;
					next_q.proto = q.proto;
					next_q.wmode = q.wmode;
					next_q.wen = q.wen;
					next_q.wstat = q.wstat;
					next_q.dly = q.dly;
					next_q.wto = q.wto;
					next_q.wcnt = q.wcnt;
				end
				next_q.nb = 3'h0;
				next_q.msdiv = '0;
				next_q.msleft = q.dly;
				next_q.st = bc ? mbh_pkg::ST_IDLE : mbh_pkg::ST_WAIT;
			end
			mbh_pkg::ST_WAIT: begin
				if (q.msleft == 16'h0000) begin
					next_q.idx = 7'h00;
					next_q.txd = tx_byte(q, 7'h00, own_addr);
					next_q.st = mbh_pkg::ST_SEND;
				end else if (q.msdiv == mbh_pkg::DIV_W'(CYC_MS - 1)) begin
					next_q.msdiv = '0;
					next_q.msleft = 16'(q.msleft - 16'h0001);
				end else begin
					next_q.msdiv = mbh_pkg::DIV_W'(q.msdiv + 1'b1);
				end
			end
			mbh_pkg::ST_SEND: begin
				if (tx_ready) begin
					if (q.idx == 7'(q.len - 7'h01)) begin
						next_q.st = mbh_pkg::ST_IDLE;
					end else begin
						next_q.idx = 7'(q.idx + 7'h01);
						next_q.txd = tx_byte(q, 7'(q.idx + 7'h01), own_addr);
					end
				end
			end
			default: next_q.st = mbh_pkg::ST_IDLE;
		endcase
		// watchdog runs after command effects so a timeout wins over a clear
		if (next_q.hok) begin
			next_q.elap = 8'h00;
		end else if (q.wen && tick && q.wto != 16'h0000) begin
			if (16'(q.elap) + 16'h0001 >= q.wto) begin
				next_q.elap = 8'h00;
				next_q.wstat = 1'b1;
				if (q.wcnt != 16'hFFFF)
					next_q.wcnt = 16'(q.wcnt + 16'h0001);
			end else begin
				next_q.elap = 8'(q.elap + 8'h01);
			end
		end
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			q <= '0;
			q.st <= mbh_pkg::ST_IDLE;
			q.dly <= mbh_pkg::RST_DELAY;
			q.wto <= mbh_pkg::RST_WTO;
			q.proto <= mbh_pkg::RST_PROTO;
		end else begin
			q <= next_q;
		end
	end

	// ==========================================================
	// outputs
	assign tx_valid           = (q.st == mbh_pkg::ST_SEND);
	assign tx_last            = tx_valid && (q.idx == 7'(q.len - 7'h01));
	assign tx_data            = q.txd;
	assign dout               = q.dout;
	assign dout_poweron       = q.dpor;
	assign wd_mode            = q.wmode;
	assign wd_enable          = q.wen;
	assign wd_status          = q.wstat;
	assign protocol_sel       = q.proto;
	assign host_alive         = q.hok;
	assign reply_delay_ms     = q.dly;
	assign host_alive_timeout = q.wto;
	assign host_alive_counter = q.wcnt;

	// ==========================================================
	// checks
	a_bcast_silent: assert property (@(posedge clk_sys) disable iff (sys_rst)
		tx_valid |-> q.rq[0] != mbh_pkg::BCAST_ADDR) else $error("broadcast answered");
	a_addr_match: assert property (@(posedge clk_sys) disable iff (sys_rst)
		tx_valid && q.idx == 7'h00 |-> tx_data == own_addr) else $error("wrong slave answered");
	a_crc_drop: assert property (@(posedge clk_sys) disable iff (sys_rst)
		q.st == mbh_pkg::ST_IDLE && rx_end && !rx_crc_ok |=> (q.st == mbh_pkg::ST_IDLE) [*3])
		else $error("bad crc frame processed");
	a_exc_length: assert property (@(posedge clk_sys) disable iff (sys_rst)
		tx_valid && q.exc != 8'h00 |-> q.len == mbh_pkg::EXC_LEN) else $error("exception len");
	a_fn_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
		tx_valid && q.idx == 7'h01 && q.exc != 8'h00 |-> tx_data[7] && tx_data[6:0] == q.rq[1][6:0])
		else $error("exception function byte");
	a_byte_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
		tx_valid && q.idx == 7'h02 && q.exc == 8'h00 && (q.rq[1] == mbh_pkg::FN_RD_HOLD ||
		q.rq[1] == mbh_pkg::FN_RD_INPUT) |-> tx_data == 8'({q.rq[5], 1'b0}))
		else $error("byte count");
	a_unsup_fn: assert property (@(posedge clk_sys) disable iff (sys_rst)
		q.st == mbh_pkg::ST_EXEC && (q.rq[1] < mbh_pkg::FN_RD_HOLD ||
		q.rq[1] > mbh_pkg::FN_WR_REG) |=> q.exc == mbh_pkg::EXC_FUNC)
		else $error("unsupported function");
	a_coil_dout: assert property (@(posedge clk_sys) disable iff (sys_rst)
		q.st == mbh_pkg::ST_EXEC && q.rq[1] == mbh_pkg::FN_WR_COIL && q.rq[0] != 8'h00 &&
		q.nb == mbh_pkg::REQ_BYTES && {q.rq[2], q.rq[3]} == mbh_pkg::COIL_DOUT &&
		{q.rq[4], q.rq[5]} == mbh_pkg::COIL_ON |=> dout) else $error("coil not applied");
	a_delay_range: assert property (@(posedge clk_sys) disable iff (sys_rst)
		reply_delay_ms <= mbh_pkg::DELAY_MAX) else $error("delay out of range");
	a_wto_range: assert property (@(posedge clk_sys) disable iff (sys_rst)
		host_alive_timeout <= mbh_pkg::WTO_MAX) else $error("timeout out of range");
	c_read_done: cover property (@(posedge clk_sys) disable iff (sys_rst)
		tx_last && tx_ready && q.exc == 8'h00 && q.rq[1] == mbh_pkg::FN_RD_HOLD);
	c_exception: cover property (@(posedge clk_sys) disable iff (sys_rst)
		tx_last && tx_ready && q.exc != 8'h00);
	c_host_ok: cover property (@(posedge clk_sys) disable iff (sys_rst) host_alive);
	c_wd_fire: cover property (@(posedge clk_sys) disable iff (sys_rst) $rose(wd_status));
endmodule // mbh_handler
`default_nettype wire

// >>> mbh_pkg.sv
// Purpose: constants for the serial register/coil command handler
// Assumes: 100 MHz clk_sys, frames arrive without their CRC bytes
// Notes:   all offsets are zero-based register/coil addresses
`default_nettype none
package mbh_pkg;
	// ==========================================================
	// function and exception codes
	localparam logic [7:0]  FN_RD_HOLD   = 8'h03;
	localparam logic [7:0]  FN_RD_INPUT  = 8'h04;
	localparam logic [7:0]  FN_WR_COIL   = 8'h05;
	localparam logic [7:0]  FN_WR_REG    = 8'h06;
	localparam logic [7:0]  EXC_FLAG     = 8'h80;
	localparam logic [7:0]  EXC_FUNC     = 8'h01;
	localparam logic [7:0]  EXC_ADDR     = 8'h02;
	localparam logic [7:0]  EXC_VALUE    = 8'h03;
	localparam logic [7:0]  BCAST_ADDR   = 8'h00;
	// ==========================================================
	// register map
	localparam logic [15:0] REG_NAME_LO  = 16'h01E2;
	localparam logic [15:0] REG_NAME_HI  = 16'h01E3;
	localparam logic [15:0] REG_SLAVE    = 16'h01E4;
	localparam logic [15:0] REG_DELAY    = 16'h01E7;
	localparam logic [15:0] REG_WTO      = 16'h01E8;
	localparam logic [15:0] REG_WCNT     = 16'h01EB;
	localparam logic [15:0] REG_HOST_OK  = 16'h3038;
	localparam logic [15:0] MAX_WORDS    = 16'h0020;
	localparam logic [15:0] DELAY_MAX    = 16'h001E;
	localparam logic [15:0] WTO_MAX      = 16'h00FF;
	// ==========================================================
	// coil map and values
	localparam logic [15:0] COIL_DOUT    = 16'h0000;
	localparam logic [15:0] COIL_DPOR    = 16'h0080;
	localparam logic [15:0] COIL_PROTO0  = 16'h0100;
	localparam logic [15:0] COIL_PROTO1  = 16'h0101;
	localparam logic [15:0] COIL_WMODE   = 16'h0103;
	localparam logic [15:0] COIL_WEN     = 16'h0104;
	localparam logic [15:0] COIL_WCLR    = 16'h010D;
	localparam logic [15:0] COIL_ON      = 16'hFF00;
	localparam logic [15:0] COIL_OFF     = 16'h0000;
	// ==========================================================
	// reset values and frame sizes
	localparam logic [15:0] RST_DELAY    = 16'h0000;
	localparam logic [15:0] RST_WTO      = 16'h0000;
	localparam logic [1:0]  RST_PROTO    = 2'h1;
	localparam logic [2:0]  REQ_BYTES    = 3'h6;
	localparam logic [6:0]  EXC_LEN      = 7'h03;
	localparam logic [6:0]  ECHO_LEN     = 7'h06;
	localparam logic [6:0]  RD_HDR_LEN   = 7'h03;
	// ==========================================================
	// timing
	localparam int          CLK_PERIOD_NS = 10;
	localparam int          DELAY_STEP_NS = 1_000_000;
	localparam int          WD_STEP_NS    = 100_000_000;
	localparam int          CYC_PER_MS    = DELAY_STEP_NS / CLK_PERIOD_NS;
	localparam int          CYC_PER_WD    = WD_STEP_NS / CLK_PERIOD_NS;
	localparam int          DIV_W         = 24;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_WAIT = 2'b10,
		ST_SEND = 2'b11
	} mbh_state_t;
endpackage
`default_nettype wire

// >>> mbh_host_model.sv
// Purpose: request master and reply sink facing the command handler
// Assumes: six byte frames, crc verdict given as a flag with frame end
// Notes:   idle request data shows the inverse of the last byte sent
`default_nettype none
module mbh_host_model (
	input  wire logic       clk_sys,
	input  wire logic       stall,
	output logic      [7:0] rx_data,
	output logic            rx_valid,
	output logic            rx_end,
	output logic            rx_crc_ok,
	output logic            tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		rx_data   = 8'h00;
		rx_valid  = 1'b0;
		rx_end    = 1'b0;
		rx_crc_ok = 1'b0;
		tx_ready  = 1'b1;
	end
	// ==========================================================
	// reply sink with random back-pressure
	always @(posedge clk_sys) begin
		tx_ready <= ~stall;
	end
	// ==========================================================
	// request sender
	task automatic send(input logic [47:0] frame, input logic crc_good);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk_sys);
			rx_data  <= frame[47 - 8 * i -: 8];
			rx_valid <= 1'b1;
		end
		@(posedge clk_sys);
		rx_valid  <= 1'b0;
		rx_data   <= ~frame[7:0];
		rx_end    <= 1'b1;
		rx_crc_ok <= crc_good;
		@(posedge clk_sys);
		rx_end    <= 1'b0;
		rx_crc_ok <= ~crc_good;
	endtask
endmodule // mbh_host_model
`default_nettype wire

// >>> mbh_handler_test.sv
// Purpose: self-checking bench for the command handler
// Assumes: short ms and watchdog ticks through parameters
// Notes:   reply bytes are checked against a queue of expected bytes
`default_nettype none
module mbh_handler_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int          CMS  = 4;
	localparam int          CWD  = 8;
	localparam logic [31:0] NAME = 32'h1234_5678; // arbitrary identifier
	localparam logic [7:0]  ME   = 8'h05;
	logic        clk_sys, sys_rst, stall, rx_valid, rx_end, rx_crc_ok;
	logic        tx_valid, tx_last, tx_ready, dout, dout_poweron;
	logic        wd_mode, wd_enable, wd_status, host_alive;
	logic [7:0]  rx_data, tx_data;
	logic [1:0]  protocol_sel;
	logic [15:0] reply_delay_ms, host_alive_timeout, host_alive_counter, v;
	logic [31:0] lfsr;
	logic [47:0] f;
	logic [5:0]  s;
	logic [8:0]  q [$];
	int          fails, comparisons, cyc, alive_cnt, lat, a;
	logic [15:0] coil [6] = '{mbh_pkg::COIL_DOUT, mbh_pkg::COIL_DPOR, mbh_pkg::COIL_WMODE,
		mbh_pkg::COIL_WEN, mbh_pkg::COIL_PROTO1, mbh_pkg::COIL_PROTO0};
	logic [47:0] bad [11] = '{48'h0507_0000_0001, 48'h0503_01E2_0000, 48'h0504_01E2_0021,
		48'h0503_0005_0001, 48'h0505_0000_1234, 48'h0506_01E7_001F,
		48'h0506_01E8_0100, 48'h0506_01EB_0001, 48'h0505_0200_FF00,
		48'h0506_0100_0001, 48'h0503_3038_0001};
	logic [7:0]  code [11] = '{8'h01, 8'h03, 8'h03, 8'h02, 8'h03, 8'h03, 8'h03, 8'h03,
		8'h02, 8'h02, 8'h02};

	mbh_handler #(.CYC_MS(CMS), .CYC_WD(CWD), .NAME_ID(NAME)) dut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .own_addr(ME), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_end(rx_end), .rx_crc_ok(rx_crc_ok), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready), .dout(dout),
		.dout_poweron(dout_poweron), .wd_mode(wd_mode), .wd_enable(wd_enable),
		.wd_status(wd_status), .protocol_sel(protocol_sel), .host_alive(host_alive),
		.reply_delay_ms(reply_delay_ms), .host_alive_timeout(host_alive_timeout),
		.host_alive_counter(host_alive_counter));
	mbh_host_model host (.clk_sys(clk_sys), .stall(stall), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_end(rx_end), .rx_crc_ok(rx_crc_ok), .tx_ready(tx_ready));

	always #5 clk_sys = ~clk_sys;
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// ==========================================================
	// reply monitor and hang guard
	always @(posedge clk_sys) begin
		lfsr  <= lfsr_next(lfsr);
		stall <= lfsr[3] & lfsr[7];
		cyc   <= cyc + 1;
		if (host_alive === 1'b1) begin
			alive_cnt <= alive_cnt + 1;
		end
		if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
			comparisons++;
			if (q.size() == 0) begin
				fails++;
				$display("unexpected at %0t: reply byte %h with none due", $time, tx_data);
			end else begin
				if ({tx_last, tx_data} !== q[0]) begin
					fails++;
					$display("unexpected at %0t: byte %h want %h", $time, {tx_last, tx_data}, q[0]);
				end
				void'(q.pop_front());
			end
		end
		if (cyc == 20000) begin
			fails++;
			$display("unexpected at %0t: run did not finish", $time);
			wrap_up();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] want, input string what);
		comparisons++;
		if (got !== want) begin
			fails++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
		end
	endtask
	// bytes are taken from the low n bytes of r, highest byte first
	task automatic txn(input logic [47:0] fr, input logic ok, input logic [63:0] r, input int n);
		int k;
		for (k = 0; k < n; k++) begin
			q.push_back({k == n - 1, r[8 * (n - 1 - k) +: 8]});
		end
		host.send(fr, ok);
		k = 0;
		if (n == 0) begin
			repeat (40) @(posedge clk_sys);
		end else begin
			while (tx_valid !== 1'b1 && k < 400) begin
				@(posedge clk_sys);
				#1;
				k++;
			end
			lat = k;
			while (q.size() != 0 && k < 800) begin
				@(posedge clk_sys);
				#1;
				k++;
			end
		end
	endtask
	task automatic wrap_up();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ==========================================================
	// main sequence
	initial begin
		clk_sys = 1'b0;
		sys_rst = 1'b1;
		stall = 1'b0;
		lfsr = 32'h0001_448C;
		fails = 0;
		comparisons = 0;
		cyc = 0;
		alive_cnt = 0;
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		chk(16'(protocol_sel), 16'h0001, "protocol at reset");
		txn(48'h0503_01E2_0002, 1'b1, 64'({24'h05_0304, NAME[15:0], NAME[31:16]}), 7);
		txn(48'h0504_01E4_0001, 1'b1, 64'({24'h05_0402, 8'h00, ME}), 5);
		$display("test reads done");
		txn(48'h0506_01E7_0010, 1'b1, 64'(48'h0506_01E7_0010), 6);
		chk(reply_delay_ms, 16'h0010, "delay register");
		txn(48'h0503_01E7_0001, 1'b1, 64'(40'h05_0302_0010), 5);
		comparisons++;
		if (lat < 16 * CMS || lat > 16 * CMS + 8) begin
			fails++;
			$display("unexpected at %0t: reply delay %0d cycles", $time, lat);
		end
		txn(48'h0506_01E7_0000, 1'b1, 64'(48'h0506_01E7_0000), 6);
		v = {8'h00, lfsr[7:0]};
		f = {32'h0506_01E8, v};
		txn(f, 1'b1, 64'(f), 6);
		chk(host_alive_timeout, v, "timeout register");
		$display("test register writes done");
		a = alive_cnt;
		txn(48'h0506_3038_0000, 1'b1, 64'(48'h0506_3038_0000), 6);
		txn(48'h0003_3038_0001, 1'b1, 64'h0, 0);
		txn(48'h0004_3038_0001, 1'b1, 64'h0, 0);
		chk(16'(alive_cnt - a), 16'h0003, "host alive pulses");
		txn(48'h0503_01E4_0001, 1'b0, 64'h0, 0);
		txn(48'h0603_01E4_0001, 1'b1, 64'h0, 0);
		$display("test silent requests done");
		for (int i = 0; i < 11; i++) begin
			txn(bad[i], 1'b1, 64'({8'h05, bad[i][39:32] | mbh_pkg::EXC_FLAG, code[i]}), 3);
		end
		$display("test exceptions done");
		txn(48'h0506_01E8_0001, 1'b1, 64'(48'h0506_01E8_0001), 6);
		txn(48'h0505_0104_FF00, 1'b1, 64'(48'h0505_0104_FF00), 6);
		repeat (6 * CWD) @(posedge clk_sys);
		txn(48'h0505_0104_0000, 1'b1, 64'(48'h0505_0104_0000), 6);
		chk(16'(wd_status), 16'h0001, "watchdog status");
		comparisons++;
		if (host_alive_counter === 16'h0000 || $isunknown(host_alive_counter)) begin
			fails++;
			$display("unexpected at %0t: timeout count stayed zero", $time);
		end
		txn(48'h0506_01EB_0000, 1'b1, 64'(48'h0506_01EB_0000), 6);
		chk(host_alive_counter, 16'h0000, "timeout count");
		txn(48'h0505_010D_FF00, 1'b1, 64'(48'h0505_010D_FF00), 6);
		chk(16'(wd_status), 16'h0000, "watchdog status cleared");
		txn(48'h0503_01EB_0001, 1'b1, 64'(40'h05_0302_0000), 5);
		$display("test watchdog done");
		// protocol code 00 comes last: the handler still echoes that write, only protocol_sel changes
		s = 6'b10_0000;
		for (int k = 0; k < 6; k++) begin
			for (int b = 1; b >= 0; b--) begin
				f = {16'h0505, coil[k], (b == 1) ? mbh_pkg::COIL_ON : mbh_pkg::COIL_OFF};
				txn(f, 1'b1, 64'(f), 6);
				s[k] = (b == 1);
				chk(16'({protocol_sel[0], protocol_sel[1], wd_enable, wd_mode, dout_poweron,
					dout}), 16'(s), "coil outputs");
			end
		end
		$display("test coils done");
		wrap_up();
	end
endmodule // mbh_handler_test
`default_nettype wire
